// ===== logic/ermc_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * enable, ready and mode control block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ERMC_REGS_SVH
`define ERMC_REGS_SVH

`define ERMC_CTRL_OFS        12'h000
`define ERMC_STATUS_OFS      12'h004
`define ERMC_IRQ_STAT_OFS    12'h008
`define ERMC_IRQ_MASK_OFS    12'h00C
`define ERMC_DEFAULTS_OFS    12'h010

`define ERMC_CTRL_FORCED_BIT 0
`define ERMC_CTRL_SINGLE_BIT 1
`define ERMC_CTRL_RST        2'h0

`define ERMC_IRQ_FAULT_BIT   0
`define ERMC_IRQ_READY_BIT   1
`define ERMC_IRQ_ENLOW_BIT   2
`define ERMC_IRQ_W           3

`define ERMC_SYNC_MIN_CYC    16'h0003
`define ERMC_SYNC_MAX_CYC    16'h0060
`define ERMC_DEFAULT_WORD    32'h0000_0046

`endif

// ===== logic/ermc_pkg.sv
/*
 * Types of the enable, ready and mode control block.
 * Assumes nothing of its surroundings.
 */
package ermc_pkg;

    typedef enum logic [1:0] {
        ERMC_INIT_LOAD   = 2'b00,
        ERMC_INIT_SAMPLE = 2'b01,
        ERMC_INIT_DONE   = 2'b10
    } ermc_init_e;

    typedef enum logic [1:0] {
        ERMC_SW_CONT     = 2'b00,
        ERMC_SW_DISCONT  = 2'b01,
        ERMC_SW_SKIP     = 2'b10,
        ERMC_SW_OFF      = 2'b11
    } ermc_sw_e;

    typedef struct packed {
        logic [1:0] voltage_select_pin;
        logic [1:0] frequency_select_pin;
        logic       sync_output_pin;
    } ermc_straps_s;

    typedef struct packed {
        logic       thermal_shutdown;
        logic       overvoltage_lockout;
    } ermc_faults_s;

endpackage

// ===== logic/ermc_top.sv
/*
 * Enable line, readiness, and switching mode control of a step-down converter,
 * with APB register access and a level interrupt.
 * Assumes synchronous inputs on pclk, an external pull on the shared enable
 * line, and nonvolatile defaults that report their own load completion.
 */
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "ermc_regs.svh"

module ermc_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  nvm_done,
    input  wire ermc_pkg::ermc_straps_s straps,
    input  wire ermc_pkg::ermc_faults_s faults,
    input  wire logic                  en_in,
    output logic                       en_out,
    output logic                       en_oe_n,
    input  wire logic                  mode_pin,
    input  wire logic                  sw_clk_tick,
    input  wire logic                  load_medium,
    input  wire logic                  load_low,
    input  wire logic                  load_very_low,
    input  wire logic                  skip_demand,
    output logic                       converter_on,
    output logic                       forced_continuous_operation,
    output logic                       power_save_operation,
    output ermc_pkg::ermc_sw_e         sw_state,
    output logic                       switch_pulse,
    output logic                       irq
);

    ermc_pkg::ermc_init_e init_q;
    ermc_pkg::ermc_straps_s straps_q;
    logic [1:0]  ctrl_q;
    logic [`ERMC_IRQ_W-1:0] istat_q;
    logic [`ERMC_IRQ_W-1:0] imask_q;
    logic        ready;
    logic        fault_any;
    logic        hold;
    logic        en_prev_q;
    logic        mode_prev_q;
    logic [15:0] sync_cnt_q;
    logic        sync_seen_q;
    logic        mode_high;
    logic        forced;
    logic        acc;
    logic [`ERMC_IRQ_W-1:0] ev;

    function automatic logic sel(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    // Initialization sequence; never revisited while powered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q <= ermc_pkg::ERMC_INIT_LOAD;
        end else if (clk_en) begin
            case (init_q)
                ermc_pkg::ERMC_INIT_LOAD: begin
                    if (nvm_done) begin
                        init_q <= ermc_pkg::ERMC_INIT_SAMPLE;
                    end
                end
                ermc_pkg::ERMC_INIT_SAMPLE: begin
                    init_q <= ermc_pkg::ERMC_INIT_DONE;
                end
                ermc_pkg::ERMC_INIT_DONE: begin
                    init_q <= ermc_pkg::ERMC_INIT_DONE;
                end
                default: begin
                    init_q <= ermc_pkg::ERMC_INIT_LOAD;
                end
            endcase
        end
    end

    // Strap capture once during sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            straps_q <= '0;
        end else if (clk_en && init_q == ermc_pkg::ERMC_INIT_SAMPLE) begin
            straps_q <= straps;
        end
    end

    assign ready     = (init_q == ermc_pkg::ERMC_INIT_DONE);
    assign fault_any = faults.thermal_shutdown | faults.overvoltage_lockout;
    // Hold while initializing, or on fault unless standalone
    assign hold = !ready ||
                  (fault_any && !ctrl_q[`ERMC_CTRL_SINGLE_BIT]);

    // Open drain: drive low only while holding
    assign en_out  = 1'b0;
    assign en_oe_n = !hold;

    // Converter runs from the shared line level, and only once ready
    assign converter_on = en_in && ready;

    // Mode selection and sync detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_prev_q <= 1'b0;
            sync_cnt_q  <= 16'h0000;
            sync_seen_q <= 1'b0;
        end else if (clk_en) begin
            mode_prev_q <= mode_pin;
            if (mode_pin != mode_prev_q) begin
                sync_cnt_q  <= 16'h0000;
                sync_seen_q <= 1'b1;
            end else if (sync_cnt_q >= `ERMC_SYNC_MAX_CYC) begin
                sync_seen_q <= 1'b0;
            end else begin
                sync_cnt_q  <= sync_cnt_q + 16'h0001;
            end
        end
    end

    assign mode_high = mode_pin || sync_seen_q;
    assign forced    = mode_high || ctrl_q[`ERMC_CTRL_FORCED_BIT];
    assign forced_continuous_operation = forced;
    assign power_save_operation        = !forced;

    // Switching state chosen from mode and load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_state     <= ermc_pkg::ERMC_SW_OFF;
            switch_pulse <= 1'b0;
        end else if (clk_en) begin
            if (!converter_on) begin
                sw_state     <= ermc_pkg::ERMC_SW_OFF;
                switch_pulse <= 1'b0;
            end else if (forced || load_medium) begin
                sw_state     <= ermc_pkg::ERMC_SW_CONT;
                switch_pulse <= sw_clk_tick;
            end else if (load_very_low) begin
                sw_state     <= ermc_pkg::ERMC_SW_SKIP;
                switch_pulse <= sw_clk_tick && skip_demand;
            end else begin
                sw_state     <= load_low ? ermc_pkg::ERMC_SW_DISCONT
                                         : ermc_pkg::ERMC_SW_CONT;
                switch_pulse <= sw_clk_tick;
            end
        end
    end

    // APB: always ready, bus active only after initialization
    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = acc && (!ready || !(sel(paddr, `ERMC_CTRL_OFS) ||
                     sel(paddr, `ERMC_STATUS_OFS) || sel(paddr, `ERMC_IRQ_STAT_OFS) ||
                     sel(paddr, `ERMC_IRQ_MASK_OFS) || sel(paddr, `ERMC_DEFAULTS_OFS)));

    // Control and mask registers; defaults not reloaded by enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `ERMC_CTRL_RST;
            imask_q <= '0;
        end else if (clk_en && acc && pwrite && ready) begin
            if (sel(paddr, `ERMC_CTRL_OFS)) begin
                ctrl_q <= pwdata[1:0];
            end
            if (sel(paddr, `ERMC_IRQ_MASK_OFS)) begin
                imask_q <= pwdata[`ERMC_IRQ_W-1:0];
            end
        end
    end

    // Sticky events; set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev_q <= 1'b0;
        end else if (clk_en) begin
            en_prev_q <= en_in;
        end
    end

    assign ev[`ERMC_IRQ_FAULT_BIT] = fault_any;
    assign ev[`ERMC_IRQ_READY_BIT] = (init_q == ermc_pkg::ERMC_INIT_SAMPLE);
    assign ev[`ERMC_IRQ_ENLOW_BIT] = en_prev_q && !en_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= '0;
        end else if (clk_en) begin
            if (acc && pwrite && ready && sel(paddr, `ERMC_IRQ_STAT_OFS)) begin
                istat_q <= (istat_q & ~pwdata[`ERMC_IRQ_W-1:0]) | ev;
            end else begin
                istat_q <= istat_q | ev;
            end
        end
    end

    assign irq = |(istat_q & imask_q);

    // Read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (sel(paddr, `ERMC_CTRL_OFS)) begin
                prdata <= {30'h0, ctrl_q};
            end else if (sel(paddr, `ERMC_STATUS_OFS)) begin
                prdata <= {20'h0, straps_q, sw_state, en_in, !en_oe_n,
                           forced, fault_any, ready};
            end else if (sel(paddr, `ERMC_IRQ_STAT_OFS)) begin
                prdata <= {29'h0, istat_q};
            end else if (sel(paddr, `ERMC_IRQ_MASK_OFS)) begin
                prdata <= {29'h0, imask_q};
            end else if (sel(paddr, `ERMC_DEFAULTS_OFS)) begin
                prdata <= `ERMC_DEFAULT_WORD;
            end
        end
    end

    // Enable pulled low whenever not ready
    property p_init_hold;
        @(posedge pclk) disable iff (!presetn) !ready |-> !en_oe_n;
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("enable not held during init");

    property p_fault_hold;
        @(posedge pclk) disable iff (!presetn)
            (fault_any && !ctrl_q[`ERMC_CTRL_SINGLE_BIT]) |-> !en_oe_n;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault not pulling enable");

    property p_single_release;
        @(posedge pclk) disable iff (!presetn)
            (ready && ctrl_q[`ERMC_CTRL_SINGLE_BIT]) |-> en_oe_n;
    endproperty
    a_single_release: assert property (p_single_release) else $error("standalone still pulls");

    property p_release;
        @(posedge pclk) disable iff (!presetn) (ready && !fault_any) |-> en_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("pulldown not released");

    property p_off;
        @(posedge pclk) disable iff (!presetn)
            (clk_en && !en_in) |=> (sw_state == ermc_pkg::ERMC_SW_OFF && !switch_pulse);
    endproperty
    a_off: assert property (p_off) else $error("switching while disabled");

    property p_no_reload;
        @(posedge pclk) disable iff (!presetn) ready |=> ready;
    endproperty
    a_no_reload: assert property (p_no_reload) else $error("initialization restarted");

    property p_forced;
        @(posedge pclk) disable iff (!presetn)
            (clk_en && converter_on && forced) |=> sw_state == ermc_pkg::ERMC_SW_CONT;
    endproperty
    a_forced: assert property (p_forced) else $error("forced mode not continuous");

    property p_skip_align;
        @(posedge pclk) disable iff (!presetn)
            (clk_en && sw_state != ermc_pkg::ERMC_SW_OFF && $rose(switch_pulse))
                |-> $past(sw_clk_tick);
    endproperty
    a_skip_align: assert property (p_skip_align) else $error("pulse off the clock");

    property p_mode_pin;
        @(posedge pclk) disable iff (!presetn) mode_pin |-> forced_continuous_operation;
    endproperty
    a_mode_pin: assert property (p_mode_pin) else $error("mode pin not forcing");

endmodule

// ===== tb/ermc_partner.sv
/* Shared enable line with pull-up, peer converter pulldown, system driver and
   an external sync clock source on the mode pin.
   Assumes pclk at 100 MHz and an active-low pulldown enable from the device. */
`timescale 1ns/1ps
module ermc_partner (
    input  wire logic pclk,
    input  wire logic dut_pull_n,
    input  wire logic host_low,
    input  wire logic peer_pull,
    input  wire logic sync_on,
    input  wire logic mode_level,
    output logic      en_line,
    output logic      mode_pin
);
    logic [5:0] div_q  = 6'h00;
    logic       sync_q = 1'b0;
    // Pull-up wins only when nobody pulls low
    assign en_line = !(!dut_pull_n || host_low || peer_pull);
    // 33 cycles each half: about 1.52 MHz at 50 percent duty
    always_ff @(posedge pclk) begin
        if (div_q == 6'h20) begin
            div_q  <= 6'h00;
            sync_q <= !sync_q;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end
    assign mode_pin = sync_on ? sync_q : mode_level;
endmodule

// ===== tb/enable_ready_mode_control_test.sv
/* Self-checking test of the enable, ready and mode control block over APB.
   Assumes the design files and the enable line partner are compiled first. */
`timescale 1ns/1ps
`include "ermc_regs.svh"
module enable_ready_mode_control_test;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [11:0]            paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata, rd;
    logic                   pready, pslverr, er, en_in, en_out, en_oe_n, mode_pin, irq;
    logic                   nvm_done = 1'b0;
    ermc_pkg::ermc_faults_s faults = '0;
    logic                   host_low = 1'b0, peer_pull = 1'b0;
    logic                   sync_on = 1'b0, mode_level = 1'b0;
    logic [3:0]             load_q = 4'h0;
    logic [2:0]             tcnt = 3'h0;
    logic                   sw_clk_tick = 1'b0, tick_n1 = 1'b0;
    logic                   converter_on, fco, pso, switch_pulse;
    ermc_pkg::ermc_sw_e     sw_state;
    int                     mismatches = 0, checked = 0;

    ermc_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nvm_done(nvm_done), .straps(5'h0B),
        .faults(faults), .en_in(en_in), .en_out(en_out), .en_oe_n(en_oe_n),
        .mode_pin(mode_pin), .sw_clk_tick(sw_clk_tick), .load_medium(load_q[3]),
        .load_low(load_q[2]), .load_very_low(load_q[1]), .skip_demand(load_q[0]),
        .converter_on(converter_on), .forced_continuous_operation(fco),
        .power_save_operation(pso), .sw_state(sw_state), .switch_pulse(switch_pulse),
        .irq(irq));
    ermc_partner i_line (.pclk(pclk), .dut_pull_n(en_oe_n), .host_low(host_low),
        .peer_pull(peer_pull), .sync_on(sync_on), .mode_level(mode_level),
        .en_line(en_in), .mode_pin(mode_pin));

    initial begin
        forever #5 pclk = !pclk;
    end
    // Internal switching clock tick every eighth cycle
    always @(posedge pclk) begin
        tcnt        <= tcnt + 3'h1;
        sw_clk_tick <= (tcnt == 3'h7);
    end
    always @(negedge pclk) begin
        if (switch_pulse === 1'b1) chk(tick_n1, 1, "pulse_after_tick");
        tick_n1 = sw_clk_tick;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #200us;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wt(4);
        chk(en_oe_n, 0, "init_hold");
        chk(en_out, 0, "pull_level");
        apb(1'b0, `ERMC_CTRL_OFS, 32'h0);
        chk(er, 1, "pre_init_refused");
        nvm_done <= 1'b1;
        wt(6);
        chk(en_oe_n, 1, "released");
        chk(converter_on, 1, "enabled");
        apb(1'b0, `ERMC_DEFAULTS_OFS, 32'h0);
        chk(rd, `ERMC_DEFAULT_WORD, "defaults");
        apb(1'b0, 12'h040, 32'h0);
        chk(er, 1, "unmapped");
        apb(1'b0, `ERMC_STATUS_OFS, 32'h0);
        chk(rd[11:7], 5'h0B, "straps");
        $display("test init done");
        apb(1'b1, `ERMC_IRQ_STAT_OFS, 32'h7);
        apb(1'b1, `ERMC_IRQ_MASK_OFS, 32'h1);
        chk(irq, 0, "irq_idle");
        faults <= 2'b10;
        wt(3);
        chk(en_oe_n, 0, "fault_pull");
        chk(converter_on, 0, "fault_stop");
        chk(sw_state, ermc_pkg::ERMC_SW_OFF, "fault_off");
        chk(irq, 1, "irq_fault");
        @(posedge pclk);
        faults <= 2'b00;
        wt(3);
        apb(1'b1, `ERMC_IRQ_STAT_OFS, 32'h1);
        wt(1);
        chk(irq, 0, "irq_cleared");
        chk(en_oe_n, 1, "fault_gone");
        apb(1'b1, `ERMC_CTRL_OFS, 32'h2);
        faults <= 2'b01;
        wt(3);
        chk(en_oe_n, 1, "standalone");
        @(posedge pclk);
        faults <= 2'b00;
        apb(1'b1, `ERMC_CTRL_OFS, 32'h0);
        apb(1'b1, `ERMC_IRQ_STAT_OFS, 32'h7);
        $display("test fault done");
        peer_pull <= 1'b1;
        wt(3);
        chk(converter_on, 0, "peer_low");
        apb(1'b0, `ERMC_IRQ_STAT_OFS, 32'h0);
        chk(er, 0, "access_while_low");
        chk(rd, 32'h4, "enable_fall_event");
        peer_pull <= 1'b0;
        wt(3);
        apb(1'b0, `ERMC_DEFAULTS_OFS, 32'h0);
        chk(rd, `ERMC_DEFAULT_WORD, "no_reload");
        apb(1'b0, `ERMC_IRQ_MASK_OFS, 32'h0);
        chk(rd, 32'h1, "mask_kept");
        $display("test enable done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `ERMC_CTRL_OFS, {31'h0, i == 1});
            mode_level <= (i == 2);
            sync_on    <= (i == 3);
            wt(100);
            chk(fco, i != 0, "forced");
            chk(pso, i == 0, "power_save");
        end
        apb(1'b1, `ERMC_CTRL_OFS, 32'h0);
        sync_on    <= 1'b0;
        mode_level <= 1'b0;
        wt(150);
        $display("test mode done");
        for (int j = 0; j < 3; j++) begin
            @(posedge pclk);
            load_q <= (j == 0) ? 4'h8 : (j == 1) ? 4'h4 : 4'h3;
            wt(30);
            chk(sw_state, j, "save_switching");
        end
        apb(1'b1, `ERMC_CTRL_OFS, 32'h1);
        wt(30);
        chk(sw_state, ermc_pkg::ERMC_SW_CONT, "forced_switching");
        $display("test load done");
        tally_and_finish();
    end
endmodule
